// [fpt_map.svh]
`ifndef FPT_MAP_SVH
`define FPT_MAP_SVH
// wishbone register offsets (byte addresses)
`define FPT_OFF_CTRL 8'h00
`define FPT_OFF_OUT_EN 8'h04
`define FPT_OFF_IN_EN 8'h08
`define FPT_OFF_WCOUNT 8'h0c
`define FPT_OFF_STORE 8'h10
`define FPT_OFF_OUT_MAP0 8'h14
`define FPT_OFF_OUT_SET0 8'h20
`define FPT_OFF_STATUS 8'h2c
`define FPT_OFF_MSG_ERR 8'h30
// reset values
`define FPT_RST_EN 8'h0f
`define FPT_RST_WCOUNT 2'h2
`define FPT_RST_SET 8'h01
`define FPT_RST_MAP0 16'h2032
`define FPT_RST_MAP1 16'h2034
`define FPT_RST_MAP2 16'h2000
// special values
`define FPT_TUNNEL_OBJ 16'h5ffd
`define FPT_MAP_OFF 16'hffff
`define FPT_EN_ALL 8'h3f
`define FPT_EN_TWO 8'h0f
`define FPT_STORE_KEY 8'hff
`define FPT_IDLE_ADDR 15'h0000
`define FPT_ERR_BIT 15
// message channel error fields
`define FPT_CLASS_ACCESS 4'h6
`define FPT_CLASS_OTHER 4'h8
`define FPT_CODE_HW_FAULT 4'h2
`define FPT_CODE_OTHER 4'h0
`define FPT_ADD_NONE 8'h00
`define FPT_ADD_BUSY 8'h22
`define FPT_ADD_NO_ASSIGN 8'h41
`endif

// [fpt_pkg.sv]
package fpt_pkg;
    typedef enum logic [3:0] {
        FPT_E_NONE, FPT_E_NO_ANSWER, FPT_E_ADDR_PROT, FPT_E_DATA, FPT_E_READ_ONLY,
        FPT_E_CHECK_BYTE, FPT_E_BUSY, FPT_E_UNSUPP, FPT_E_PASSWORD, FPT_E_FRAME,
        FPT_E_PARITY, FPT_E_SET, FPT_E_LANGUAGE, FPT_E_ADDR, FPT_E_OPERATION
    } fpt_err_t;
    typedef enum logic [1:0] {FPT_T_OFF, FPT_T_16, FPT_T_32} fpt_tmode_t;
endpackage

// [fpt_inv_if.sv]
// parameter access toward the inverter
interface fpt_inv_if;
    logic req;
    logic wr;
    logic [14:0] addr;
    logic [31:0] wdata;
    logic [7:0] sets;
    logic done;
    logic err;
    logic [3:0] code;
    logic [31:0] rdata;
    modport ctl (output req, wr, addr, wdata, sets, input done, err, code, rdata);
    modport port (input req, wr, addr, wdata, sets, output done, err, code, rdata);
endinterface

// [fpt_inv_port.sv]
`include "fpt_map.svh"
// drives one access at a time onto the inverter request pins
module fpt_inv_port import fpt_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // toward the controller
    fpt_inv_if.port cp,
    // inverter pins
    output logic inv_req,
    output logic inv_wr,
    output logic [14:0] inv_addr,
    output logic [31:0] inv_wdata,
    output logic [7:0] inv_sets,
    input wire logic inv_ack,
    input wire logic inv_err,
    input wire logic [3:0] inv_code,
    input wire logic [31:0] inv_rdata
);
    logic busy_reg;
    logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            ack_s3_reg <= 1'b0;
        end else begin
            ack_s1_reg <= inv_ack;
            ack_s2_reg <= ack_s1_reg;
            ack_s3_reg <= ack_s2_reg;
        end
    end
    wire ack_rise = ack_s2_reg && !ack_s3_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
            inv_req <= 1'b0;
            inv_wr <= 1'b0;
            inv_addr <= '0;
            inv_wdata <= '0;
            inv_sets <= '0;
        end else if (!busy_reg && cp.req) begin
            busy_reg <= 1'b1;
            inv_req <= 1'b1;
            inv_wr <= cp.wr;
            inv_addr <= cp.addr;
            inv_wdata <= cp.wdata;
            inv_sets <= cp.sets;
        end else if (busy_reg && ack_rise) begin
            busy_reg <= 1'b0;
            inv_req <= 1'b0;
        end
    end
    // answer pins are stable while ack is high, two flops late is safe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cp.done <= 1'b0;
            cp.err <= 1'b0;
            cp.code <= '0;
            cp.rdata <= '0;
        end else begin
            cp.done <= busy_reg && ack_rise;
            if (busy_reg && ack_rise) begin
                cp.err <= inv_err;
                cp.code <= inv_code;
                cp.rdata <= inv_rdata;
            end
        end
    end
endmodule // fpt_inv_port

// [fpt_tunnel.sv]
// The address map and register access over Wishbone are this design's own decisions.
`include "fpt_map.svh"
module fpt_tunnel import fpt_pkg::*; #(
    parameter logic [15:0] ID_WORD = 16'h1357, // arbitrary identification value
    parameter int WORDS = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bus cycle and bus reset from the fieldbus chip
    input wire logic bus_cycle,
    input wire logic bus_reset,
    // process words
    input wire logic [15:0] out_word0,
    input wire logic [15:0] out_word1,
    input wire logic [15:0] out_word2,
    output logic [15:0] in_word0,
    output logic [15:0] in_word1,
    output logic [15:0] in_word2,
    // non-volatile store, count strap from memory
    input wire logic [1:0] nv_word_count,
    output logic nv_store,
    // inverter
    output logic inv_req,
    output logic inv_wr,
    output logic [14:0] inv_addr,
    output logic [31:0] inv_wdata,
    output logic [7:0] inv_sets,
    input wire logic inv_ack,
    input wire logic inv_err,
    input wire logic [3:0] inv_code,
    input wire logic [31:0] inv_rdata,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o
);
    fpt_inv_if ii();
    fpt_inv_port u_port (
        .clk(clk),
        .rst_b(rst_b),
        .cp(ii.port),
        .inv_req(inv_req),
        .inv_wr(inv_wr),
        .inv_addr(inv_addr),
        .inv_wdata(inv_wdata),
        .inv_sets(inv_sets),
        .inv_ack(inv_ack),
        .inv_err(inv_err),
        .inv_code(inv_code),
        .inv_rdata(inv_rdata)
    );

    // pin synchronisers
    logic [1:0] cyc_s_reg, rst_s_reg;
    logic [15:0] o0_s1_reg, o1_s1_reg, o2_s1_reg, o0_reg, o1_reg, o2_reg;
    logic [15:0] p0_reg, p1_reg, p2_reg;
    logic cyc_d_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_s_reg <= '0;
            rst_s_reg <= '0;
            o0_s1_reg <= '0;
            o1_s1_reg <= '0;
            o2_s1_reg <= '0;
            o0_reg <= '0;
            o1_reg <= '0;
            o2_reg <= '0;
            cyc_d_reg <= 1'b0;
        end else begin
            cyc_s_reg <= {cyc_s_reg[0], bus_cycle};
            rst_s_reg <= {rst_s_reg[0], bus_reset};
            o0_s1_reg <= out_word0;
            o1_s1_reg <= out_word1;
            o2_s1_reg <= out_word2;
            o0_reg <= o0_s1_reg;
            o1_reg <= o1_s1_reg;
            o2_reg <= o2_s1_reg;
            cyc_d_reg <= cyc_s_reg[1];
        end
    end
    wire cyc_tick = cyc_s_reg[1] && !cyc_d_reg;
    wire brst = rst_s_reg[1];

    // configuration
    logic [7:0] out_en_reg, in_en_reg, ctrl_reg;
    logic [1:0] count_cfg_reg, count_reg;
    logic count_loaded_reg;
    logic [15:0] map_reg [WORDS];
    logic [7:0] set_reg [WORDS];
    logic [15:0] msg_err_reg;
    logic store_pend_reg;
    wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_hit && wb_we_i && wb_sel_i[0];

    // power-up count taken one clock after release
    // count at powerup
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= `FPT_RST_WCOUNT;
            count_loaded_reg <= 1'b0;
        end else if (!count_loaded_reg) begin
            count_reg <= nv_word_count;
            count_loaded_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_en_reg <= `FPT_RST_EN;
            in_en_reg <= `FPT_RST_EN;
            count_cfg_reg <= `FPT_RST_WCOUNT;
            ctrl_reg <= '0;
            map_reg[0] <= `FPT_RST_MAP0;
            map_reg[1] <= `FPT_RST_MAP1;
            map_reg[2] <= `FPT_RST_MAP2;
            for (int i = 0; i < WORDS; i++) set_reg[i] <= `FPT_RST_SET;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                `FPT_OFF_CTRL: ctrl_reg <= wb_dat_i[7:0];
                `FPT_OFF_OUT_EN: out_en_reg <= wb_dat_i[7:0] & `FPT_EN_ALL;
                `FPT_OFF_IN_EN: in_en_reg <= wb_dat_i[7:0] & `FPT_EN_ALL;
                `FPT_OFF_WCOUNT: count_cfg_reg <= wb_dat_i[1:0];
                `FPT_OFF_OUT_MAP0: map_reg[0] <= wb_dat_i[15:0];
                8'h18: map_reg[1] <= wb_dat_i[15:0];
                8'h1c: map_reg[2] <= wb_dat_i[15:0];
                `FPT_OFF_OUT_SET0: set_reg[0] <= wb_dat_i[7:0];
                8'h24: set_reg[1] <= wb_dat_i[7:0];
                8'h28: set_reg[2] <= wb_dat_i[7:0];
                default: ;
            endcase
            // a write to any output map or set register disables all output words until re-enabled
            if (wb_adr_i >= `FPT_OFF_OUT_MAP0 && wb_adr_i <= 8'h28 &&
                wb_adr_i[1:0] == 2'b00)
                out_en_reg <= '0;
        end else if (wb_hit && !wb_we_i && wb_adr_i == `FPT_OFF_OUT_EN) begin
            out_en_reg <= out_en_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_store <= 1'b0;
        end else begin
            nv_store <= wb_wr && wb_adr_i == `FPT_OFF_STORE && wb_dat_i[7:0] == `FPT_STORE_KEY;
        end
    end

    // active words; enable bits 0, 2, 4
    fpt_tmode_t tmode;
    logic [WORDS-1:0] out_act, in_act;
    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_act
            assign out_act[g] = (count_reg > 2'(g)) && out_en_reg[2*g] &&
                                map_reg[g] != `FPT_MAP_OFF;
            assign in_act[g] = (count_reg > 2'(g)) && (in_en_reg[2*g] || tmode != FPT_T_OFF);
        end
    endgenerate

    always_comb begin
        tmode = FPT_T_OFF;
        if (map_reg[0] == `FPT_TUNNEL_OBJ && count_reg == 2'd3) begin
            if (out_en_reg == `FPT_EN_ALL && map_reg[2] != `FPT_MAP_OFF)
                tmode = FPT_T_32;
            else if (out_en_reg == `FPT_EN_TWO && map_reg[2] == `FPT_MAP_OFF)
                tmode = FPT_T_16;
        end
    end

    wire t_wr = o0_reg[`FPT_ERR_BIT];
    wire [14:0] t_addr = o0_reg[14:0];
    wire [31:0] t_wdata = (tmode == FPT_T_32) ? {o1_reg, o2_reg} : {{16{o1_reg[15]}}, o1_reg};
    wire out_changed = (o0_reg != p0_reg) || (o1_reg != p1_reg) || (o2_reg != p2_reg);

    // sequencing: tunnel access or process word resend
    logic busy_reg, resend_reg, wr_done_reg, in_flight_reg;
    logic [1:0] widx_reg;
    logic req_reg;
    assign ii.req = req_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
            req_reg <= 1'b0;
            resend_reg <= 1'b0;
            wr_done_reg <= 1'b0;
            widx_reg <= '0;
            p0_reg <= '0;
            p1_reg <= '0;
            p2_reg <= '0;
            ii.wr <= 1'b0;
            ii.addr <= '0;
            ii.wdata <= '0;
            ii.sets <= '0;
            in_word0 <= '0;
            in_word1 <= ID_WORD;
            in_word2 <= '0;
            in_flight_reg <= 1'b0;
        end else if (brst) begin
            busy_reg <= 1'b0;
            req_reg <= 1'b0;
            wr_done_reg <= 1'b0;
            in_word0 <= '0;
            in_word1 <= ID_WORD;
            in_word2 <= '0;
        end else begin
            req_reg <= 1'b0;
            if (!busy_reg && cyc_tick) begin
                if (out_changed) wr_done_reg <= 1'b0;
                p0_reg <= o0_reg;
                p1_reg <= o1_reg;
                p2_reg <= o2_reg;
                if (tmode != FPT_T_OFF) begin
                    if (t_addr == `FPT_IDLE_ADDR) begin
                        in_word0 <= '0;
                        in_word1 <= ID_WORD;
                        in_word2 <= '0;
                    end else if (!t_wr || out_changed || !wr_done_reg) begin
                        busy_reg <= 1'b1;
                        req_reg <= 1'b1;
                        ii.wr <= t_wr;
                        ii.addr <= t_addr;
                        ii.wdata <= t_wdata;
                        ii.sets <= set_reg[0];
                    end
                end else if (out_changed && out_act != '0) begin
                    resend_reg <= 1'b1;
                    widx_reg <= '0;
                end else if (resend_reg) begin
                    if (out_act[widx_reg]) begin
                        busy_reg <= 1'b1;
                        req_reg <= 1'b1;
                        ii.wr <= 1'b1;
                        ii.addr <= map_reg[widx_reg][14:0];
                        ii.wdata <= {16'h0000, widx_reg == 2'd0 ? o0_reg :
                                     widx_reg == 2'd1 ? o1_reg : o2_reg};
                        ii.sets <= set_reg[widx_reg];
                    end
                    if (widx_reg == 2'(WORDS - 1)) resend_reg <= 1'b0;
                    widx_reg <= widx_reg + 2'd1;
                end
            end
            if (busy_reg && ii.done) begin
                busy_reg <= 1'b0;
                if (tmode != FPT_T_OFF) begin
                    if (ii.wr) wr_done_reg <= 1'b1;
                    in_word0 <= {ii.err, ii.addr};
                    if (ii.err) begin
                        in_word1 <= {12'h000, ii.code};
                        in_word2 <= '0;
                    end else if (tmode == FPT_T_32) begin
                        in_word1 <= ii.wr ? ii.wdata[31:16] : ii.rdata[31:16];
                        in_word2 <= ii.wr ? ii.wdata[15:0] : ii.rdata[15:0];
                    end else begin
                        in_word1 <= ii.wr ? ii.wdata[15:0] : ii.rdata[15:0];
                    end
                end else begin
                    in_word0 <= in_act[0] ? ii.rdata[15:0] : in_word0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            msg_err_reg <= '0;
        end else if (busy_reg && ii.done && ii.err) begin
            msg_err_reg <= (ii.code == FPT_E_NO_ANSWER) ?
                {`FPT_CLASS_ACCESS, `FPT_CODE_HW_FAULT, `FPT_ADD_NONE} :
                (ii.code == FPT_E_BUSY) ?
                {`FPT_CLASS_OTHER, `FPT_CODE_OTHER, `FPT_ADD_BUSY} :
                {`FPT_CLASS_OTHER, `FPT_CODE_OTHER, `FPT_ADD_NO_ASSIGN};
        end
    end

    // wishbone read and ack
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i)
                    `FPT_OFF_CTRL: wb_dat_o <= {24'h0, ctrl_reg};
                    `FPT_OFF_OUT_EN: wb_dat_o <= {24'h0, out_en_reg};
                    `FPT_OFF_IN_EN: wb_dat_o <= {24'h0, in_en_reg};
                    `FPT_OFF_WCOUNT: wb_dat_o <= {28'h0, count_reg, count_cfg_reg};
                    `FPT_OFF_OUT_MAP0: wb_dat_o <= {16'h0, map_reg[0]};
                    8'h18: wb_dat_o <= {16'h0, map_reg[1]};
                    8'h1c: wb_dat_o <= {16'h0, map_reg[2]};
                    `FPT_OFF_OUT_SET0: wb_dat_o <= {24'h0, set_reg[0]};
                    8'h24: wb_dat_o <= {24'h0, set_reg[1]};
                    8'h28: wb_dat_o <= {24'h0, set_reg[2]};
                    `FPT_OFF_STATUS: wb_dat_o <= {24'h0, busy_reg, wr_done_reg, tmode,
                                                  1'b0, in_act};
                    `FPT_OFF_MSG_ERR: wb_dat_o <= {16'h0, msg_err_reg};
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end
endmodule // fpt_tunnel

// [fpt_tunnel_chk.sv]
module fpt_tunnel_chk import fpt_pkg::*; #(
    parameter logic [15:0] ID_WORD = 16'h1357
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // process side
    input wire logic bus_cycle,
    input wire logic bus_reset,
    input wire logic [15:0] out_word0,
    input wire logic [15:0] out_word1,
    input wire logic [15:0] out_word2,
    input wire logic [15:0] in_word0,
    input wire logic [15:0] in_word1,
    input wire logic nv_store,
    // inverter
    input wire logic inv_req,
    input wire logic inv_wr,
    input wire logic [14:0] inv_addr,
    input wire logic inv_ack,
    // wishbone
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] quiet_reg;
    logic [3:0] since_reg;
    // cycles since the host last changed an output word, accessed a register or raised bus reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) quiet_reg <= 8'h00;
        else if ($changed(out_word0) || $changed(out_word1) || $changed(out_word2)
            || wb_ack_o || bus_reset) quiet_reg <= 8'h00;
        else if (quiet_reg != 8'hff) quiet_reg <= quiet_reg + 8'h01;
    end
    // cycles since anything that may update the input words
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) since_reg <= 4'h0;
        else if (inv_ack || bus_reset || bus_cycle || wb_ack_o) since_reg <= 4'h0;
        else if (since_reg != 4'hf) since_reg <= since_reg + 4'h1;
    end
    a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_unmapped_zero: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == 8'h34)
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_store_key: assert property ((wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_sel_i[0] && wb_adr_i == 8'h10 && wb_dat_i[7:0] == 8'hff) |-> ##[1:2] nv_store)
        else $error("store key gave no pulse");
    a_store_pulse: assert property (nv_store |=> !nv_store)
        else $error("store pulse too long");
    a_idle_ident: assert property ($rose(rst_b) |-> in_word1 == ID_WORD)
        else $error("identity missing after reset");
    a_req_holds: assert property ((inv_req && !inv_ack) |=>
        inv_req && $stable(inv_addr) && $stable(inv_wr)) else $error("request dropped early");
    a_write_once: assert property (($rose(inv_req) && inv_wr) |-> quiet_reg < 8'd200)
        else $error("write without a changed word");
    a_in_quiet: assert property (!$stable(in_word0) |-> since_reg < 4'd12)
        else $error("input word changed without cause");
endmodule // fpt_tunnel_chk
bind fpt_tunnel fpt_tunnel_chk #(.ID_WORD(ID_WORD)) u_chk (.clk, .rst_b, .bus_cycle,
    .bus_reset, .out_word0, .out_word1, .out_word2, .in_word0, .in_word1, .nv_store,
    .inv_req, .inv_wr, .inv_addr, .inv_ack, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// [fpt_inv_model.sv]
module fpt_inv_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // answer speed
    input wire logic slow,
    // request pins
    input wire logic inv_req,
    input wire logic inv_wr,
    input wire logic [14:0] inv_addr,
    input wire logic [31:0] inv_wdata,
    // answer pins
    output logic inv_ack,
    output logic inv_err,
    output logic [3:0] inv_code,
    output logic [31:0] inv_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [16];
    logic [31:0] last_wd;
    logic [2:0] wait_cnt;
    logic bad;
    int n_wr;
    initial foreach (mem[i]) mem[i] = 32'h0;
    assign bad = inv_addr[14:12] == 3'h7;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inv_ack <= 1'b0;
            inv_err <= 1'b0;
            inv_code <= 4'h0;
            inv_rdata <= 32'h0;
            wait_cnt <= 3'h0;
        end else if (!inv_req) begin
            // ack stays up until the request drops
            wait_cnt <= 3'h0;
            if (inv_ack) begin
                // released answer lines stop holding the last value
                inv_ack <= 1'b0;
                inv_err <= ~inv_err;
                inv_rdata <= ~inv_rdata;
                inv_code <= ~inv_code;
            end
        end else if (!inv_ack && wait_cnt == (slow ? 3'h5 : 3'h1)) begin
            inv_ack <= 1'b1;
            // error code taken from the address
            inv_err <= bad;
            inv_code <= bad ? inv_addr[3:0] : 4'h0;
            inv_rdata <= mem[inv_addr[3:0]];
            if (inv_wr && !bad) begin
                mem[inv_addr[3:0]] <= inv_wdata;
                last_wd <= inv_wdata;
                n_wr <= n_wr + 1;
            end
        end else if (!inv_ack) wait_cnt <= wait_cnt + 3'h1;
    end
endmodule // fpt_inv_model

// [tb_fieldbus_process_data_param_tunnel.sv]
`include "fpt_map.svh"
module tb_fieldbus_process_data_param_tunnel import fpt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] ID = 16'h1357; // arbitrary identification value
    logic clk, rst_b, bus_cycle, bus_reset, nv_store, slow, inv_req, inv_wr, inv_ack, inv_err;
    logic [15:0] out_word0, out_word1, out_word2, in_word0, in_word1, in_word2;
    logic [1:0] nv_word_count;
    logic [14:0] inv_addr;
    logic [31:0] inv_wdata, inv_rdata, wb_dat_i, wb_dat_o, rd;
    logic [7:0] inv_sets, wb_adr_i;
    logic [3:0] inv_code, wb_sel_i;
    logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    int n_mismatch = 0, checks_done = 0, cyc_cnt = 0, n_store = 0, w;
    fpt_tunnel #(.ID_WORD(ID), .WORDS(3)) dut (.*);
    fpt_inv_model inv (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (nv_store === 1'b1) n_store <= n_store + 1;
        if (cyc_cnt == 80000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_sel_i <= 4'hf;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk) bus_cycle <= 1'b1;
            repeat (2) @(posedge clk);
            bus_cycle <= 1'b0;
            repeat (30) @(posedge clk);
        end
    endtask
    task automatic setw(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clk);
        out_word0 <= a;
        out_word1 <= b;
        out_word2 <= c;
    endtask
    task automatic echo(input logic [15:0] e);
        for (int i = 0; i < 20 && in_word0 !== e; i++) tick(1);
        chk(in_word0, e);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {rst_b, bus_cycle, bus_reset, slow, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
        {out_word0, out_word1, out_word2, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        nv_word_count = 2'h3;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(in_word1, ID);
        wbx(1'b0, `FPT_OFF_OUT_MAP0, 0); chk(rd, 32'h2032);
        wbx(1'b0, `FPT_OFF_OUT_SET0, 0); chk(rd, 32'h01);
        wbx(1'b0, `FPT_OFF_OUT_EN, 0); chk(rd, 32'h0f);
        wbx(1'b0, 8'h34, 0); chk(rd, 32'h0);
        wbx(1'b0, `FPT_OFF_WCOUNT, 0); chk(rd, 32'he);
        wbx(1'b1, `FPT_OFF_STORE, 32'h7e);
        wbx(1'b1, `FPT_OFF_STORE, 32'hff);
        @(posedge clk);
        chk(n_store, 1);
        $display("test registers done");
        tick(2);
        w = inv.n_wr;
        setw(16'h0, 16'h0100, 16'h0);
        tick(3);
        chk(inv.n_wr - w, 2);
        $display("test forward done");
        wbx(1'b1, `FPT_OFF_OUT_MAP0, 32'h5ffd);
        wbx(1'b1, 8'h18, 32'h0);
        wbx(1'b1, 8'h1c, 32'hffff);
        wbx(1'b1, `FPT_OFF_OUT_SET0, 32'hff);
        wbx(1'b1, `FPT_OFF_OUT_EN, 32'h0f);
        setw(16'h0, 16'h0, 16'h0);
        tick(2);
        chk(in_word1, ID);
        inv.mem[1] = 32'h44;
        setw(16'h2101, 16'h5a5a, 16'h0);
        echo(16'h2101);
        chk(in_word1, 16'h0044);
        chk(inv_sets, 8'hff);
        inv.mem[1] = 32'h45;
        tick(3);
        chk(in_word1, 16'h0045);
        for (int k = 1; k < 15; k++) begin
            setw(16'h7000 + 16'(k), 16'h0, 16'h0);
            echo(16'hf000 + 16'(k));
            chk(in_word1, 32'(k));
            if (k == 1 || k == 6) begin
                wbx(1'b0, `FPT_OFF_MSG_ERR, 0);
                chk(rd, k == 1 ? 32'h6200 : 32'h8022);
            end
        end
        $display("test tunnel read done");
        w = inv.n_wr;
        setw(16'hb302, 16'h1234, 16'h0);
        echo(16'h3302);
        chk(in_word1, 16'h1234);
        tick(3);
        chk(inv.n_wr - w, 1);
        setw(16'h0, 16'h1234, 16'h0);
        echo(16'h0);
        setw(16'hb302, 16'h1234, 16'h0);
        echo(16'h3302);
        tick(2);
        chk(inv.n_wr - w, 2);
        $display("test tunnel write done");
        slow <= 1'b1;
        wbx(1'b1, 8'h1c, 32'h0);
        wbx(1'b1, `FPT_OFF_OUT_EN, 32'h3f);
        setw(16'h8003, 16'hffff, 16'he0c0);
        echo(16'h0003);
        chk(inv.last_wd, 32'hffffe0c0);
        setw(16'h0, 16'h0, 16'h0);
        echo(16'h0);
        setw(16'h0003, 16'h0, 16'h0);
        echo(16'h0003);
        chk({in_word1, in_word2}, 32'hffffe0c0);
        // read address still held: only the bus reset can bring back idle
        @(posedge clk) bus_reset <= 1'b1;
        repeat (4) @(posedge clk);
        bus_reset <= 1'b0;
        repeat (3) @(posedge clk);
        chk(in_word0, 16'h0);
        chk(in_word1, ID);
        $display("test 32-bit and bus reset done");
        final_report();
    end
endmodule // tb_fieldbus_process_data_param_tunnel
